// [smsp_pkg.sv]
package smsp_pkg;

    // -------------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------------
    localparam int          ADDR_W        = 2;
    localparam logic [1:0]  ADDR_CTRL     = 2'h0;
    localparam logic [1:0]  ADDR_STAT     = 2'h1;
    localparam logic [1:0]  ADDR_DATA     = 2'h2;
    localparam logic [7:0]  CTRL_RESET    = 8'h14;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;

    // status field positions
    localparam int          STAT_DONE_BIT = 7;
    localparam int          STAT_OVR_BIT  = 5;
    localparam int          STAT_MODE_FAULT_FLAG_BIT = 4;
    localparam int          STAT_TXE_BIT  = 3;
    localparam int          STAT_TEIE_BIT = 1;

    // -------------------------------------------------------------------------
    // shift engine constants
    // -------------------------------------------------------------------------
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam logic [2:0]  BIT_ZERO      = 3'h0;
    localparam logic [2:0]  RATE_MIN      = 3'h1;
    localparam logic [2:0]  RATE_MAX      = 3'h6;
    localparam logic [6:0]  HALF_NONE     = 7'h00;
    localparam logic [6:0]  HALF_BASE     = 7'h01;
    localparam int          SYNC_W        = 4;

    // -------------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic       rateSelectBit2;
        logic       portEnable;
        logic       ssDisable;
        logic       masterSelect;
        logic       clockPolarity;
        logic       clockPhase;
        logic       rateSelectBit1;
        logic       rateSelectBit0;
    } smsp_ctrl_s;

    typedef struct packed {
        logic       sck;
        logic       mosi;
        logic       miso;
        logic       ss;
    } smsp_pins_s;

    typedef struct packed {
        logic       sckOut;
        logic       sckOe_n;
        logic       mosiOut;
        logic       mosiOe_n;
        logic       misoOut;
        logic       misoOe_n;
    } smsp_pad_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } smsp_state_e;

    // half of the sck period in core clocks; zero for the unusable codes
    function automatic logic [6:0] smsp_half(input logic [2:0] code);
        if (code >= RATE_MIN && code <= RATE_MAX) begin
            return HALF_BASE << code;
        end
        return HALF_NONE;
    endfunction

endpackage

// [smsp_sync.sv]
`timescale 1ns/1ns
module smsp_sync
    import smsp_pkg::*;
#(
    parameter int W = SYNC_W
) (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    // -------------------------------------------------------------------------
    // two-stage synchroniser, first stage feeds only the second
    // -------------------------------------------------------------------------
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

// [smsp_core.sv]
`timescale 1ns/1ns
module smsp_core
    import smsp_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [7:0]        regRdData,
    input  wire smsp_pins_s        pinIn,
    output smsp_pad_s              padOut,
    output logic                   ssPinFree,
    output logic                   txEmpty,
    output logic                   irqReq
);

    // -------------------------------------------------------------------------
    // pin synchronisation
    // -------------------------------------------------------------------------
    smsp_pins_s  pinS;
    logic        sckPrev_q;
    logic        ssPrev_q;

    smsp_sync #(
        .W (SYNC_W)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .asyncIn  (pinIn),
        .syncOut  (pinS)
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sckPrev_q <= 1'b0;
            ssPrev_q  <= 1'b1;
        end else begin
            sckPrev_q <= pinS.sck;
            ssPrev_q  <= pinS.ss;
        end
    end

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    smsp_ctrl_s  ctrl_q;
    logic        teie_q;
    logic        done_q;
    logic        doneArm_q;
    logic        ovr_q;
    logic        mode_fault_flag_q;
    logic        modfArm_q;
    logic [7:0]  txBuf_q;
    logic        txFull_q;
    logic [7:0]  rxData_q;
    logic        rxFull_q;
    logic [7:0]  shift_q;
    logic        latchBit_q;
    logic        outBit_q;
    logic [2:0]  bitCnt_q;
    smsp_state_e state_q;
    logic [6:0]  halfCnt_q;
    logic        sckLevel_q;
    logic        frame_q;
    localparam smsp_ctrl_s CTRL_INIT = CTRL_RESET;

    // -------------------------------------------------------------------------
    // decode
    // -------------------------------------------------------------------------
    logic [6:0] half;
    logic       isMaster;
    logic       isSlave;
    logic       ssUsed;
    logic       selected;
    logic       slvLead;
    logic       slvTrail;
    logic       mstTick;
    logic       lead;
    logic       trail;
    logic       dataIn;
    logic       byteDone;
    logic       load;
    logic       mstFault;
    logic       slvFault;
    logic       ctrlWr;
    logic       statWr;
    logic       dataWr;
    logic       statRd;
    logic       dataRd;
    logic       rxAccept;
    logic       dataOut;
    logic [7:0] rxByte;

    assign half     = smsp_half({ctrl_q.rateSelectBit2, ctrl_q.rateSelectBit1,
                                 ctrl_q.rateSelectBit0});
    assign isMaster = ctrl_q.portEnable & ctrl_q.masterSelect;
    assign isSlave  = ctrl_q.portEnable & ~ctrl_q.masterSelect;
    assign ssUsed   = ~(ctrl_q.ssDisable & ctrl_q.clockPhase);
    assign selected = ssUsed ? ~pinS.ss : 1'b1;

    // slave edges only count while selected
    assign slvLead  = isSlave & selected & (pinS.sck != ctrl_q.clockPolarity)
                      & (sckPrev_q == ctrl_q.clockPolarity);
    assign slvTrail = isSlave & selected & (pinS.sck == ctrl_q.clockPolarity)
                      & (sckPrev_q != ctrl_q.clockPolarity) & (state_q == ST_SHIFT);
    assign mstTick  = isMaster & (state_q == ST_SHIFT) & (halfCnt_q == HALF_NONE)
                      & (half != HALF_NONE);
    assign lead     = slvLead | (mstTick & (sckLevel_q == ctrl_q.clockPolarity));
    assign trail    = slvTrail | (mstTick & (sckLevel_q != ctrl_q.clockPolarity));
    assign dataIn   = isMaster ? pinS.miso : pinS.mosi;
    assign byteDone = trail & (bitCnt_q == BIT_LAST);

    // phase0 samples on lead and shifts on trail, phase1 the other way round
    // miso lags the master's own sck by two clocks, so a master takes it at trail
    assign rxByte   = {shift_q[6:0], (ctrl_q.clockPhase | isMaster) ? dataIn : latchBit_q};
    assign dataOut  = ctrl_q.clockPhase ? outBit_q : shift_q[7];

    assign load     = txFull_q & ((isMaster & (((state_q == ST_IDLE) & (half != HALF_NONE))
                      | byteDone)) | (isSlave & selected & (state_q == ST_IDLE)
                      & ~slvLead));

    assign mstFault = isMaster & ~ctrl_q.ssDisable & ~pinS.ss;
    assign slvFault = isSlave & ssUsed & pinS.ss & ~ssPrev_q & frame_q;

    assign ctrlWr   = regWrite & (regAddr == ADDR_CTRL);
    assign statWr   = regWrite & (regAddr == ADDR_STAT);
    assign dataWr   = regWrite & (regAddr == ADDR_DATA);
    assign statRd   = regRead & (regAddr == ADDR_STAT);
    assign dataRd   = regRead & (regAddr == ADDR_DATA);
    assign rxAccept = byteDone & (~rxFull_q | dataRd);

    // -------------------------------------------------------------------------
    // control register
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            if (ctrlWr) begin
                ctrl_q <= regWrData;
            end
            if (mstFault) begin
                ctrl_q.portEnable   <= 1'b0;
                ctrl_q.masterSelect <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            teie_q <= 1'b0;
        end else if (statWr) begin
            teie_q <= regWrData[STAT_TEIE_BIT];
        end
    end

    // -------------------------------------------------------------------------
    // status flags, a set always beats a clear
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            done_q    <= 1'b0;
            doneArm_q <= 1'b0;
            ovr_q     <= 1'b0;
        end else begin
            if (statRd) begin
                doneArm_q <= done_q;
            end else if (dataRd) begin
                doneArm_q <= 1'b0;
            end
            if (byteDone) begin
                done_q <= 1'b1;
            end else if (dataRd & doneArm_q) begin
                done_q <= 1'b0;
            end
            if (byteDone & ~rxAccept) begin
                ovr_q <= 1'b1;
            end else if (dataRd & doneArm_q) begin
                ovr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_fault_flag_q    <= 1'b0;
            modfArm_q <= 1'b0;
        end else begin
            if (statRd) begin
                modfArm_q <= mode_fault_flag_q;
            end else if (ctrlWr) begin
                modfArm_q <= 1'b0;
            end
            if (mstFault | slvFault) begin
                mode_fault_flag_q <= 1'b1;
            end else if (ctrlWr & modfArm_q) begin
                mode_fault_flag_q <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // transmit buffer and receive register
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txBuf_q  <= BYTE_ZERO;
            txFull_q <= 1'b0;
        end else begin
            if (dataWr) begin
                txBuf_q  <= regWrData;
                txFull_q <= 1'b1;
            end else if (load | ~ctrl_q.portEnable) begin
                txFull_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rxData_q <= BYTE_ZERO;
            rxFull_q <= 1'b0;
        end else begin
            if (rxAccept) begin
                rxData_q <= rxByte;
                rxFull_q <= 1'b1;
            end else if (dataRd) begin
                rxFull_q <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // slave framing
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            frame_q <= 1'b0;
        end else if (~isSlave | ~ssUsed | pinS.ss | byteDone) begin
            frame_q <= 1'b0;
        end else if (ssPrev_q | slvLead) begin
            frame_q <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // shift engine and master clock
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q    <= ST_IDLE;
            shift_q    <= BYTE_ZERO;
            latchBit_q <= 1'b0;
            outBit_q   <= 1'b0;
            bitCnt_q   <= BIT_ZERO;
            halfCnt_q  <= HALF_NONE;
            sckLevel_q <= CTRL_INIT.clockPolarity;
        end else if (~ctrl_q.portEnable) begin
            state_q    <= ST_IDLE;
            bitCnt_q   <= BIT_ZERO;
            halfCnt_q  <= HALF_NONE;
            sckLevel_q <= ctrl_q.clockPolarity;
        end else if (isSlave & ~selected) begin
            state_q  <= ST_IDLE;
            bitCnt_q <= BIT_ZERO;
        end else begin
            if (mstTick) begin
                sckLevel_q <= ~sckLevel_q;
                halfCnt_q  <= half - HALF_BASE;
            end else if (halfCnt_q != HALF_NONE) begin
                halfCnt_q <= halfCnt_q - HALF_BASE;
            end
            if (lead) begin
                latchBit_q <= dataIn;
                outBit_q   <= shift_q[7];
                state_q    <= ST_SHIFT;
            end
            if (trail) begin
                shift_q  <= rxByte;
                bitCnt_q <= bitCnt_q + 3'h1;
                if (byteDone) begin
                    state_q <= ST_IDLE;
                end
            end
            if (load) begin
                shift_q   <= txBuf_q;
                bitCnt_q  <= BIT_ZERO;
                state_q   <= isMaster ? ST_SHIFT : ST_IDLE;
                halfCnt_q <= isMaster ? half - HALF_BASE : HALF_NONE;
            end
            if (~isMaster) begin
                sckLevel_q <= ctrl_q.clockPolarity;
            end
        end
    end

    // -------------------------------------------------------------------------
    // register read port
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            regRdData <= BYTE_ZERO;
        end else if (regRead) begin
            unique case (regAddr)
                ADDR_CTRL: regRdData <= ctrl_q;
                ADDR_STAT: begin
                    regRdData                <= BYTE_ZERO;
                    regRdData[STAT_DONE_BIT] <= done_q;
                    regRdData[STAT_OVR_BIT]  <= ovr_q;
                    regRdData[STAT_MODE_FAULT_FLAG_BIT] <= mode_fault_flag_q;
                    regRdData[STAT_TXE_BIT]  <= ~txFull_q;
                    regRdData[STAT_TEIE_BIT] <= teie_q;
                end
                ADDR_DATA: regRdData <= rxData_q;
                default:   regRdData <= BYTE_ZERO;
            endcase
        end else begin
            regRdData <= BYTE_ZERO;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign txEmpty   = ~txFull_q;
    assign irqReq    = (done_q & ~teie_q) | (~txFull_q & teie_q) | mode_fault_flag_q;
    assign ssPinFree = ctrl_q.ssDisable;

    always_comb begin
        padOut          = '0;
        padOut.sckOut   = sckLevel_q;
        padOut.sckOe_n  = ~isMaster;
        padOut.mosiOut  = dataOut;
        padOut.mosiOe_n = ~isMaster;
        padOut.misoOut  = dataOut;
        padOut.misoOe_n = ~(isSlave & selected);
    end

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence ssRiseInFrame;
        isSlave & ssUsed & frame_q & ~ssPrev_q ##0 pinS.ss;
    endsequence

    sequence faultRaised;
        mode_fault_flag_q & irqReq;
    endsequence

    txEmptyClear_a: assert property (dataWr |=> ~txEmpty)
        else $error("empty flag still set after data write");
    masterFault_a: assert property (mstFault |=> mode_fault_flag_q & ~ctrl_q.portEnable
        & ~ctrl_q.masterSelect) else $error("master fault not taken");
    slaveFault_a: assert property (ssRiseInFrame |=> faultRaised)
        else $error("slave deselect fault missed");
    misoRelease_a: assert property (isSlave & ~selected |-> padOut.misoOe_n
        ##1 ~frame_q) else $error("miso driven while deselected");
    overrunKeep_a: assert property (byteDone & rxFull_q & ~dataRd |=>
        ovr_q & $stable(rxData_q)) else $error("overrun lost unread byte");
    doneIrq_a: assert property (byteDone & ~teie_q & ~statWr |=> done_q
        & irqReq) else $error("done flag did not interrupt");
    emptyIrq_a: assert property (teie_q & ~txFull_q |-> irqReq)
        else $error("empty flag did not interrupt");
    disableIdle_a: assert property (~ctrl_q.portEnable |=> bitCnt_q == BIT_ZERO
        & state_q == ST_IDLE & sckLevel_q == $past(ctrl_q.clockPolarity))
        else $error("disable did not reset shifter");
    fastRate_a: assert property (mstTick & half == 7'h02 & ~load & ~trail
        |=> ~mstTick ##1 mstTick) else $error("sck half period wrong");

endmodule

// [smsp_peer.sv]
`timescale 1ns/1ns
// far-side slave, mode 0 only, answers with a fixed pair of bytes
module smsp_peer (
    input  wire logic       sck,
    input  wire logic       selN,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      rxByte,
    output logic [7:0]      rxPrev
);
    logic [7:0] tx;
    logic [7:0] sh;
    logic [7:0] reply [2];
    int         bits;
    int         idx;

    initial begin
        reply  = '{8'h96, 8'hC3};
        bits   = 0;
        idx    = 0;
        sh     = 8'h00;
        tx     = 8'h96;
        miso   = 1'b1;
        rxByte = 8'h00;
        rxPrev = 8'h00;
    end

    // msb stands on the line before the first edge
    always @(negedge selN) begin
        bits = 0;
        tx   = reply[idx];
        miso = tx[7];
    end

    // released line shows the inverse of its last value
    always @(posedge selN) miso = ~miso;

    always @(posedge sck) begin
        if (!selN) begin
            sh = {sh[6:0], mosi};
            bits++;
            if (bits == 8) begin
                rxPrev = rxByte;
                rxByte = sh;
                bits   = 0;
                idx    = (idx + 1) % 2;
            end
        end
    end

    always @(negedge sck) begin
        if (!selN) begin
            if (bits == 0) tx = reply[idx];
            else tx = {tx[6:0], 1'b0};
            miso = tx[7];
        end
    end
endmodule

// [spi_master_slave_port_tb_top.sv]
`timescale 1ns/1ns
module spi_master_slave_port_tb_top
    import smsp_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              srst     = 1'b1;
    logic              regWrite = 1'b0;
    logic              regRead  = 1'b0;
    logic              ssN      = 1'b1;
    logic              peerSelN = 1'b1;
    logic              tbSck    = 1'b0;
    logic              tbMosi   = 1'b0;
    logic [7:0]        slvGot;
    logic [ADDR_W-1:0] regAddr  = '0;
    logic [7:0]        regWrData = 8'h00;
    logic [7:0]        regRdData;
    logic [7:0]        peerRx;
    logic [7:0]        peerPrev;
    smsp_pad_s         padOut;
    smsp_pins_s        pins;
    logic              ssPinFree;
    logic              txEmpty;
    logic              irqReq;
    logic              sckW;
    logic              mosiW;
    logic              misoW;
    logic              peerMiso;
    int                miscompares = 0;
    int                n_checks = 0;
    time               leads[$];

    // bench acts as remote master while the block is a slave
    assign sckW  = padOut.sckOe_n ? tbSck : padOut.sckOut;
    assign mosiW = padOut.mosiOe_n ? tbMosi : padOut.mosiOut;
    assign misoW = padOut.misoOe_n ? peerMiso : padOut.misoOut;
    assign pins  = {sckW, mosiW, misoW, ssN};

    smsp_core dut (.core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pinIn(pins),
        .padOut(padOut), .ssPinFree(ssPinFree), .txEmpty(txEmpty), .irqReq(irqReq));
    smsp_peer peer (.sck(sckW), .selN(peerSelN), .mosi(mosiW), .miso(peerMiso),
        .rxByte(peerRx), .rxPrev(peerPrev));

    always #2 core_clk = ~core_clk;
    always @(posedge sckW) if (!peerSelN) leads.push_back($time);

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
        #1;
    endtask

    task automatic rdc(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        chk(what, regRdData, exp);
    endtask

    // remote master in phase0: every sck level lasts four core clocks
    task automatic slvByte(input logic [7:0] d, output logic [7:0] got);
        for (int i = 7; i >= 0; i--) begin
            tbMosi <= d[i];
            repeat (3) @(posedge core_clk);
            #1;
            got[i] = misoW;
            @(posedge core_clk);
            tbSck <= 1'b1;
            repeat (4) @(posedge core_clk);
            tbSck <= 1'b0;
        end
    endtask

    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // whole run is well under 2000 cycles
    initial begin
        #40000;
        miscompares++;
        report_and_stop;
    end

    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        rdc(ADDR_CTRL, CTRL_RESET, "control");
        rdc(ADDR_STAT, 8'h08, "status");
        wr(2'h3, 8'hFF);
        rdc(2'h3, BYTE_ZERO, "unmapped");
        rdc(ADDR_CTRL, CTRL_RESET, "control");
        wr(ADDR_STAT, 8'h02);
        chk("irq", {7'h00, irqReq}, 8'h01);
        rdc(ADDR_STAT, 8'h0A, "status");
        wr(ADDR_STAT, 8'h00);
        chk("irq", {7'h00, irqReq}, 8'h00);
        $display("test registers finished");
        @(posedge core_clk);
        peerSelN <= 1'b0;
        wr(ADDR_CTRL, 8'h11);
        wr(ADDR_CTRL, 8'h51);
        wr(ADDR_DATA, 8'hA5);
        chk("txEmpty", {7'h00, txEmpty}, 8'h00);
        repeat (3) @(posedge core_clk);
        #1;
        chk("txEmpty", {7'h00, txEmpty}, 8'h01);
        wr(ADDR_DATA, 8'h3C);
        chk("txEmpty", {7'h00, txEmpty}, 8'h00);
        repeat (120) @(posedge core_clk);
        #1;
        chk("lead count", 8'(leads.size()), 8'h10);
        chk("sck period", 8'((leads[1] - leads[0]) / 4), 8'h04);
        chk("burst span", 8'((leads[15] - leads[0]) / 4), 8'h3C);
        chk("peer first", peerPrev, 8'hA5);
        chk("peer second", peerRx, 8'h3C);
        chk("irq", {7'h00, irqReq}, 8'h01);
        rdc(ADDR_STAT, 8'hA8, "status");
        rdc(ADDR_DATA, 8'h96, "data");
        rdc(ADDR_STAT, 8'h08, "status");
        $display("test master transfer finished");
        @(posedge core_clk);
        peerSelN <= 1'b1;
        ssN      <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        chk("irq", {7'h00, irqReq}, 8'h01);
        rdc(ADDR_STAT, 8'h18, "status");
        rdc(ADDR_CTRL, 8'h01, "control");
        @(posedge core_clk);
        ssN <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr(ADDR_CTRL, 8'h01);
        rdc(ADDR_STAT, 8'h08, "status");
        chk("irq", {7'h00, irqReq}, 8'h00);
        $display("test mode fault finished");
        wr(ADDR_CTRL, 8'h10);
        wr(ADDR_CTRL, 8'h50);
        @(posedge core_clk);
        leads.delete();
        peerSelN <= 1'b0;
        wr(ADDR_DATA, 8'h5A);
        repeat (100) @(posedge core_clk);
        #1;
        chk("lead count", 8'(leads.size()), 8'h00);
        chk("txEmpty", {7'h00, txEmpty}, 8'h00);
        wr(ADDR_CTRL, 8'h10);
        @(posedge core_clk);
        #1;
        chk("txEmpty", {7'h00, txEmpty}, 8'h01);
        rdc(ADDR_CTRL, 8'h10, "control");
        $display("test unusable rate finished");
        @(posedge core_clk);
        peerSelN <= 1'b1;
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        chk("ss free", {7'h00, ssPinFree}, 8'h00);
        wr(ADDR_DATA, 8'hC3);
        @(posedge core_clk);
        ssN <= 1'b0;
        repeat (4) @(posedge core_clk);
        slvByte(8'h5A, slvGot);
        chk("slave first", slvGot, 8'hC3);
        repeat (4) @(posedge core_clk);
        ssN <= 1'b1;
        rdc(ADDR_STAT, 8'h88, "status");
        rdc(ADDR_DATA, 8'h5A, "data");
        @(posedge core_clk);
        ssN <= 1'b0;
        repeat (4) @(posedge core_clk);
        slvByte(8'h81, slvGot);
        chk("slave resend", slvGot, 8'h5A);
        repeat (4) @(posedge core_clk);
        ssN <= 1'b1;
        rdc(ADDR_STAT, 8'h88, "status");
        rdc(ADDR_DATA, 8'h81, "data");
        @(posedge core_clk);
        ssN <= 1'b0;
        repeat (4) @(posedge core_clk);
        ssN <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk("miso release", {7'h00, padOut.misoOe_n}, 8'h01);
        rdc(ADDR_STAT, 8'h18, "status");
        wr(ADDR_CTRL, 8'h20);
        chk("ss free", {7'h00, ssPinFree}, 8'h01);
        $display("test slave transfer finished");
        report_and_stop;
    end
endmodule
